// *** verilog/adc_top.v ***
// Datapath cells with an Avalon-MM register slave
//
// Design decisions made here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "adc_regs.vh"

module adc_top (
  input  wire        i_core_clk,
  input  wire        i_sys_rst,
  input  wire [5:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output reg         o_avs_waitrequest,
  output reg  [3:0]  o_shr_data,
  output reg  [1:0]  o_sel_out,
  output reg  [3:0]  o_sgn_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_ACK  = 1'b1;

  reg        st_q;
  reg        st_d;
  reg [7:0]  add_a_q;
  reg [7:0]  add_b_q;
  reg [1:0]  add_ctrl_q;
  reg [7:0]  sel_data_q;
  reg [3:0]  sel_ctrl_q;
  reg [5:0]  sgn_ctrl_q;
  reg [3:0]  shr_q;
  reg [3:0]  shr_d;
  reg [31:0] rdata_d;
  wire [1:0] sel_d;
  reg [3:0]  sgn_d;

  wire       req;
  wire       wr_take;
  wire       wr_low;
  wire [7:0] wbyte;
  wire [7:0] a_eff;
  wire [7:0] b_eff;
  wire       cin_eff;
  wire [7:0] sum_raw;
  wire [4:0] carry;
  wire [7:0] sum_res;
  wire       cout_res;

  assign req     = i_avs_read | i_avs_write;
  assign wr_take = i_avs_write & (st_q == ST_ACK);
  assign wr_low  = wr_take & i_avs_byteenable[0];
  assign wbyte   = i_avs_writedata[7:0];

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle, then accept
  // ----------------------------------------------------------------
  always @* begin
    case (st_q)
      ST_IDLE: st_d = req ? ST_ACK : ST_IDLE;
      ST_ACK:  st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_q              <= ST_IDLE;
      o_avs_waitrequest <= 1'b1;
    end else begin
      st_q              <= st_d;
      o_avs_waitrequest <= ~(st_d == ST_ACK);
    end
  end

  // ----------------------------------------------------------------
  // Software-written control registers
  // ----------------------------------------------------------------
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      add_a_q    <= `ADC_RST_BYTE;
      add_b_q    <= `ADC_RST_BYTE;
      add_ctrl_q <= `ADC_RST_ADD_CTRL;
      sel_data_q <= `ADC_RST_BYTE;
      sel_ctrl_q <= `ADC_RST_NIB;
      sgn_ctrl_q <= `ADC_RST_SGN_CTRL;
    end else if (wr_low) begin
      case (i_avs_address)
        `ADC_OFF_ADD_A:    add_a_q    <= wbyte;
        `ADC_OFF_ADD_B:    add_b_q    <= wbyte;
        `ADC_OFF_ADD_CTRL: add_ctrl_q <= wbyte[1:0];
        `ADC_OFF_SEL_DATA: sel_data_q <= wbyte;
        `ADC_OFF_SEL_CTRL: sel_ctrl_q <= wbyte[3:0];
        `ADC_OFF_SGN_CTRL: sgn_ctrl_q <= wbyte[5:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Adder chain
  // ----------------------------------------------------------------
  // Active-low mode drives inverted operands and inverts the results back
  assign a_eff   = add_ctrl_q[`ADC_ADD_ALOW_BIT] ? ~add_a_q : add_a_q;
  assign b_eff   = add_ctrl_q[`ADC_ADD_ALOW_BIT] ? ~add_b_q : add_b_q;
  assign cin_eff = add_ctrl_q[`ADC_ADD_ALOW_BIT] ^ add_ctrl_q[`ADC_ADD_CIN_BIT];
  assign carry[0] = cin_eff;

  genvar gi;
  generate
    for (gi = 0; gi < `ADC_NUM_CELLS; gi = gi + 1) begin : g_add
      adc_add2 u_cell (
        .i_operand_a_bit_low  (a_eff[2*gi]),
        .i_operand_b_bit_low  (b_eff[2*gi]),
        .i_operand_a_bit_high (a_eff[2*gi+1]),
        .i_operand_b_bit_high (b_eff[2*gi+1]),
        .i_carry_in           (carry[gi]),
        .o_sum_bit_low        (sum_raw[2*gi]),
        .o_sum_bit_high       (sum_raw[2*gi+1]),
        .o_carry_out          (carry[gi+1])
      );
    end
  endgenerate

  assign sum_res  = add_ctrl_q[`ADC_ADD_ALOW_BIT] ? ~sum_raw : sum_raw;
  assign cout_res = add_ctrl_q[`ADC_ADD_ALOW_BIT] ^ carry[`ADC_NUM_CELLS];

  // ----------------------------------------------------------------
  // Dual selector and sign extension cell
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_sel
      // Local bit per section keeps one driver per process
      reg sect_d;

      always @* begin
        if (sel_ctrl_q[`ADC_SEL_STB0_BIT + gi]) begin
          sect_d = 1'b0;
        end else begin
          // Shared select pair, bit 1 is the high-order select
          sect_d = sel_data_q[4*gi + sel_ctrl_q[1:0]];
        end
      end

      assign sel_d[gi] = sect_d;
    end
  endgenerate

  always @* begin
    case ({sgn_ctrl_q[`ADC_SGN_INH_BIT], sgn_ctrl_q[`ADC_SGN_CTL_BIT]})
      2'b00:   sgn_d = ~sgn_ctrl_q[3:0];
      2'b01:   sgn_d = sgn_ctrl_q[3:0];
      2'b10:   sgn_d = 4'hF;
      2'b11:   sgn_d = 4'h0;
      default: sgn_d = 4'h0;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_sel_out <= `ADC_RST_SEL_OUT;
      o_sgn_out <= `ADC_RST_NIB;
    end else begin
      o_sel_out <= sel_d;
      o_sgn_out <= sgn_d;
    end
  end

  // ----------------------------------------------------------------
  // Four-bit shift register, one step per command write
  // ----------------------------------------------------------------
  // Load tied high by software gives a two-state mode set
  always @* begin
    shr_d = shr_q;
    if (wr_low && (i_avs_address == `ADC_OFF_SHR_CMD)) begin
      if (wbyte[`ADC_SHR_SHIFT_BIT]) begin
        shr_d = {wbyte[`ADC_SHR_SIN_BIT], shr_q[3:1]};
      end else if (wbyte[`ADC_SHR_LOAD_BIT]) begin
        shr_d = wbyte[7:4];
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      shr_q      <= `ADC_RST_NIB;
      o_shr_data <= `ADC_RST_NIB;
    end else begin
      shr_q      <= shr_d;
      o_shr_data <= shr_d;
    end
  end

  // ----------------------------------------------------------------
  // Read mux, latched at the cycle the request is first seen
  // ----------------------------------------------------------------
  always @* begin
    rdata_d = `ADC_RST_WORD;
    case (i_avs_address)
      `ADC_OFF_ADD_A:     rdata_d[7:0] = add_a_q;
      `ADC_OFF_ADD_B:     rdata_d[7:0] = add_b_q;
      `ADC_OFF_ADD_CTRL:  rdata_d[1:0] = add_ctrl_q;
      `ADC_OFF_ADD_RES:   rdata_d[8:0] = {cout_res, sum_res};
      `ADC_OFF_SEL_DATA:  rdata_d[7:0] = sel_data_q;
      `ADC_OFF_SEL_CTRL:  rdata_d[3:0] = sel_ctrl_q;
      `ADC_OFF_SEL_RES:   rdata_d[1:0] = sel_d;
      `ADC_OFF_SHR_STATE: rdata_d[3:0] = shr_q;
      `ADC_OFF_SGN_CTRL:  rdata_d[5:0] = sgn_ctrl_q;
      `ADC_OFF_SGN_RES:   rdata_d[3:0] = sgn_d;
      default:            rdata_d = `ADC_RST_WORD;
    endcase
  end

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_avs_readdata <= `ADC_RST_WORD;
    end else if (i_avs_read && (st_q == ST_IDLE)) begin
      o_avs_readdata <= rdata_d;
    end
  end

endmodule

// *** verilog/adc_regs.vh ***
// Register offsets, field positions and reset values of the datapath cells
`ifndef ADC_REGS_VH
`define ADC_REGS_VH

// ----------------------------------------------------------------
// Byte offsets on the register bus
// ----------------------------------------------------------------
`define ADC_OFF_ADD_A     6'h00
`define ADC_OFF_ADD_B     6'h04
`define ADC_OFF_ADD_CTRL  6'h08
`define ADC_OFF_ADD_RES   6'h0C
`define ADC_OFF_SEL_DATA  6'h10
`define ADC_OFF_SEL_CTRL  6'h14
`define ADC_OFF_SEL_RES   6'h18
`define ADC_OFF_SHR_CMD   6'h1C
`define ADC_OFF_SHR_STATE 6'h20
`define ADC_OFF_SGN_CTRL  6'h24
`define ADC_OFF_SGN_RES   6'h28

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ADC_ADD_CIN_BIT   0
`define ADC_ADD_ALOW_BIT  1
`define ADC_ADD_COUT_BIT  8
`define ADC_SEL_STB0_BIT  2
`define ADC_SEL_STB1_BIT  3
`define ADC_SHR_LOAD_BIT  0
`define ADC_SHR_SHIFT_BIT 1
`define ADC_SHR_SIN_BIT   2
`define ADC_SGN_INH_BIT   4
`define ADC_SGN_CTL_BIT   5

// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define ADC_NUM_CELLS     4
`define ADC_WORD_W        8
`define ADC_RST_BYTE      8'h00
`define ADC_RST_NIB       4'h0
`define ADC_RST_ADD_CTRL  2'h0
`define ADC_RST_SEL_OUT   2'h0
`define ADC_RST_SGN_CTRL  6'h00
`define ADC_RST_WORD      32'h0000_0000

`endif

// *** verilog/adc_add2.v ***
// Two-bit full adder slice with carry in and carry out
`timescale 1ns/1ps
`include "adc_regs.vh"

module adc_add2 (
  input  wire i_operand_a_bit_low,
  input  wire i_operand_b_bit_low,
  input  wire i_operand_a_bit_high,
  input  wire i_operand_b_bit_high,
  input  wire i_carry_in,
  output wire o_sum_bit_low,
  output wire o_sum_bit_high,
  output wire o_carry_out
);

  wire [2:0] total;

  // Plain binary sum is self-dual, so active-low use works unchanged
  assign total = {1'b0, i_operand_a_bit_high, i_operand_a_bit_low}
               + {1'b0, i_operand_b_bit_high, i_operand_b_bit_low}
               + {2'b00, i_carry_in};
  assign o_sum_bit_low  = total[0];
  assign o_sum_bit_high = total[1];
  assign o_carry_out    = total[2];

endmodule

// *** verif/adc_props.sv ***
// Checker for the bus handshake and the selector, sign and shift register cells
`timescale 1ns/1ps
module adc_props (
  input wire        i_core_clk,
  input wire        i_sys_rst,
  input wire [5:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0]  i_avs_byteenable,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  input wire [3:0]  o_shr_data,
  input wire [1:0]  o_sel_out,
  input wire [3:0]  o_sgn_out
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  wire       wr_ok = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
  wire       shr   = wr_ok && i_avs_address == 6'h1C;
  wire [7:0] wd    = i_avs_writedata[7:0];
  function automatic [3:0] sgn_ref(input [7:0] v);
    sgn_ref = v[4] ? {4{~v[5]}} : (v[5] ? v[3:0] : ~v[3:0]);
  endfunction
  a_read_answer: assert property ($rose(i_avs_read) |=> !o_avs_waitrequest)
    else $error("read not answered");
  a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("wait low too long");
  a_shr_hold: assert property (shr && wd[1:0] == 2'b00 |=> $stable(o_shr_data))
    else $error("hold changed data");
  a_shr_load: assert property (shr && wd[1:0] == 2'b01 |=> o_shr_data == $past(wd[7:4]))
    else $error("load wrong");
  a_shr_shift: assert property (shr && wd[1]
    |=> o_shr_data == {$past(wd[2]), $past(o_shr_data[3:1])}) else $error("shift wrong");
  a_shr_still: assert property (!shr |=> $stable(o_shr_data))
    else $error("data moved without command");
  a_sel_strobe: assert property (wr_ok && i_avs_address == 6'h14
    |-> ##2 (o_sel_out & $past(wd[3:2], 2)) == 2'b00) else $error("strobe ignored");
  a_sgn_func: assert property (wr_ok && i_avs_address == 6'h24
    |-> ##2 o_sgn_out == sgn_ref($past(wd, 2))) else $error("sign cell wrong");
  c_shift: cover property (shr && wd[1]);
  c_load: cover property (shr && wd[1:0] == 2'b01);
  c_sgn: cover property (wr_ok && i_avs_address == 6'h24);
endmodule
bind adc_top adc_props i_props (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_shr_data(o_shr_data), .o_sel_out(o_sel_out), .o_sgn_out(o_sgn_out));

// *** verif/adc_ctl_model.sv ***
// Sequencing controller model that drives the cells over the bus
`timescale 1ns/1ps
module adc_ctl_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_wait,
  input  wire logic [31:0] i_rdata,
  output logic      [5:0]  o_addr  = 6'h00,
  output logic             o_read  = 1'b0,
  output logic             o_write = 1'b0,
  output logic      [31:0] o_wdata = 32'h0000_0000,
  output logic      [3:0]  o_be    = 4'h0
);
  task automatic wr_byte(input logic [5:0] a, input logic [7:0] d, input logic [3:0] b);
    @(posedge i_core_clk);
    o_addr  <= a;
    o_wdata <= {24'h0, d};
    o_be    <= b;
    o_write <= 1'b1;
    do @(posedge i_core_clk); while (i_wait !== 1'b0);
    o_write <= 1'b0;
    // Released data flips so a stale value is never mistaken for a fresh one
    o_wdata <= ~o_wdata;
  endtask
  task automatic rd_word(input logic [5:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_read <= 1'b1;
    do @(posedge i_core_clk); while (i_wait !== 1'b0);
    d = i_rdata;
    o_read <= 1'b0;
  endtask
endmodule

// *** verif/adc_tb_top.sv ***
// Self-checking bench for the datapath cells
`timescale 1ns/1ps
module adc_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  addr;
  logic        rd, wr, wt;
  logic [31:0] wdata, rdata, r;
  logic [3:0]  be, shr, sgn, q;
  logic [1:0]  sel;
  logic [8:0]  s;
  logic [7:0]  av [3] = '{8'hFF, 8'h5A, 8'h12};
  logic [7:0]  bv [3] = '{8'h01, 8'hA5, 8'hED};
  logic [7:0]  cv [5] = '{8'hC1, 8'h00, 8'h06, 8'h03, 8'hF1};
  int          err_total = 0;
  int          num_checks = 0;
  always #2 clk = ~clk;
  adc_top i_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wt), .o_shr_data(shr), .o_sel_out(sel),
    .o_sgn_out(sgn));
  adc_ctl_model i_ctl (.i_core_clk(clk), .i_wait(wt), .i_rdata(rdata), .o_addr(addr),
    .o_read(rd), .o_write(wr), .o_wdata(wdata), .o_be(be));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    i_ctl.rd_word(a, r);
    chk(r, exp);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog: tests need well under a thousand cycles
  initial begin
    #20000;
    err_total++;
    wrap_up;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // First pair ripples a carry through every cell while active-low is off
    for (int m = 0; m < 4; m++)
      for (int k = 0; k < 3; k++) begin
        i_ctl.wr_byte(6'h00, av[k], 4'hF);
        i_ctl.wr_byte(6'h04, bv[k], 4'hF);
        i_ctl.wr_byte(6'h08, 8'(m), 4'hF);
        s = av[k] + bv[k] + m[0];
        rchk(6'h0C, {23'h0, s});
      end
    i_ctl.wr_byte(6'h10, 8'h96, 4'hF);
    for (int c = 0; c < 16; c++) begin
      i_ctl.wr_byte(6'h14, 8'(c), 4'hF);
      s[1] = !c[3] && ((4'h9 >> c[1:0]) & 4'h1);
      s[0] = !c[2] && ((4'h6 >> c[1:0]) & 4'h1);
      rchk(6'h18, {30'h0, s[1:0]});
      chk({30'h0, sel}, {30'h0, s[1:0]});
    end
    for (int c = 0; c < 4; c++) begin
      i_ctl.wr_byte(6'h24, {2'b00, c[1:0], 4'hA}, 4'hF);
      q = c[0] ? {4{~c[1]}} : (c[1] ? 4'hA : 4'h5);
      rchk(6'h28, {28'h0, q});
      chk({28'h0, sgn}, {28'h0, q});
    end
    // Last command has the low byte lane off and must be dropped
    q = 4'h0;
    for (int i = 0; i < 5; i++) begin
      i_ctl.wr_byte(6'h1C, cv[i], (i == 4) ? 4'hE : 4'hF);
      if (i < 4)
        q = cv[i][1] ? {cv[i][2], q[3:1]} : (cv[i][0] ? cv[i][7:4] : q);
      rchk(6'h20, {28'h0, q});
      chk({28'h0, shr}, {28'h0, q});
    end
    rchk(6'h1C, 32'h0);
    rchk(6'h2C, 32'h0);
    wrap_up;
  end
endmodule
